// [design/sdt_pkg.sv]
// package: constants for the screen data transfer controller
package sdt_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] SDT_OFS_CTRL = 8'h00;
	localparam logic [7:0] SDT_OFS_STATUS = 8'h04;
	localparam logic [7:0] SDT_OFS_PROGRESS = 8'h08;
	localparam logic [7:0] SDT_OFS_SWITCH = 8'h0c;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int SDT_CTRL_EXEC_BIT = 0;
	localparam int SDT_CTRL_DIR_BIT = 1;
	localparam int SDT_CTRL_BANK_BIT = 2;
	localparam int SDT_CTRL_ACK_BIT = 3;
	localparam logic SDT_CTRL_DIR_RST = 1'h0;
	localparam logic SDT_CTRL_BANK_RST = 1'h0;
	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int SDT_ST_PHASE_LSB = 0;
	localparam int SDT_ST_MODE_ERR_BIT = 4;
	localparam int SDT_ST_PROT_ERR_BIT = 5;
	localparam int SDT_ST_VERIFY_ERR_BIT = 6;
	localparam int SDT_ST_AUTO_BIT = 7;
	localparam int SDT_ST_MANUAL_BIT = 8;
	localparam int SDT_ST_DIR_BIT = 9;
	localparam int SDT_ST_BANK_BIT = 10;
	localparam int SDT_ST_MOUNTED_BIT = 11;
	localparam int SDT_ST_WAIT_EXEC_BIT = 12;
	// ------------------------------------------------------------
	// switch positions in the sampled switch word
	// ------------------------------------------------------------
	localparam int SDT_SW_U2T = 0;
	localparam int SDT_SW_T2U = 1;
	localparam int SDT_SW_MANUAL = 2;
	localparam int SDT_SW_MODE_RSV = 3;
	localparam int SDT_SW_TERM_WE = 4;
	localparam int SDT_SW_UNIT_WE = 5;
	localparam int SDT_SW_BANK = 6;
	localparam int SDT_SW_PROT_RSV = 7;
	// ------------------------------------------------------------
	// image layout and timing
	// ------------------------------------------------------------
	localparam int SDT_IMAGE_AW = 20;
	localparam int SDT_BLOCK_BITS = 4;
	localparam int SDT_CLK_MHZ = 200;
	localparam int SDT_SETTLE_US = 10;
	localparam int SDT_SETTLE_CYC = SDT_SETTLE_US * SDT_CLK_MHZ;
	localparam int SDT_PREP_US = 5;
	localparam int SDT_PREP_CYC = SDT_PREP_US * SDT_CLK_MHZ;
	localparam int SDT_BLINK_HALF_MS = 250;
	localparam int SDT_BLINK_HALF_CYC = SDT_BLINK_HALF_MS * 1000 * SDT_CLK_MHZ;
	// ------------------------------------------------------------
	// main sequence states
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		SDT_SAMPLE = 8'h01,
		SDT_CHECK = 8'h02,
		SDT_MAN_IDLE = 8'h04,
		SDT_PREP = 8'h08,
		SDT_XMIT = 8'h10,
		SDT_VERIFY = 8'h20,
		SDT_DONE = 8'h40,
		SDT_ERR = 8'h80
	} sdt_state_t;
endpackage

// [design/sdt_ctrl.sv]
// module: screen data transfer controller between terminal flash and memory unit
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module sdt_ctrl
	import sdt_pkg::*;
#(
	parameter int AW = SDT_IMAGE_AW,
	parameter int BLINK_HALF_CYC = SDT_BLINK_HALF_CYC
)
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// memory unit switches and presence
	input wire logic auto_unit_to_term_sel_in,
	input wire logic auto_term_to_unit_sel_in,
	input wire logic manual_xfer_sel_in,
	input wire logic mode_group_reserved_in,
	input wire logic term_write_enable_in,
	input wire logic unit_write_enable_in,
	input wire logic auto_bank_select_in,
	input wire logic protect_group_reserved_in,
	input wire logic unit_mounted_in,
	// terminal flash port
	output logic term_req_out,
	output logic term_we_out,
	output logic [AW-1:0] term_addr_out,
	output logic [7:0] term_wdata_out,
	input wire logic [7:0] term_rdata_in,
	input wire logic term_ack_in,
	// memory unit flash port, msb of address is the bank
	output logic unit_req_out,
	output logic unit_we_out,
	output logic [AW:0] unit_addr_out,
	output logic [7:0] unit_wdata_out,
	input wire logic [7:0] unit_rdata_in,
	input wire logic unit_ack_in,
	// indicators
	output logic run_indicator_out,
	output logic alarm_out,
	output logic [3:0] phase_out,
	output logic normal_op_en_out
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic one_hot3(input logic [2:0] v);
		one_hot3 = (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
	endfunction

	// destination of a copy may be written: terminal for dir 0, unit for dir 1
	function automatic logic dest_writable(input logic dir, input logic [7:0] sw);
		dest_writable = dir ? sw[SDT_SW_UNIT_WE] : sw[SDT_SW_TERM_WE];
	endfunction

	localparam logic [31:0] SETTLE_MAX = 32'(SDT_SETTLE_CYC - 1);
	localparam logic [31:0] PREP_MAX = 32'(SDT_PREP_CYC - 1);
	localparam logic [31:0] BLINK_MAX = 32'(BLINK_HALF_CYC - 1);
	localparam logic [AW-1:0] ADDR_LAST = {AW{1'b1}};

	sdt_state_t state_r;
	logic [7:0] sw_meta_r;
	logic [7:0] sw_sync_r;
	logic mnt_meta_r;
	logic mnt_sync_r;
	logic [7:0] sw_lat_r;
	logic [31:0] cnt_r;
	logic auto_r;
	logic manual_r;
	logic dir_r;
	logic bank_r;
	logic step_r;
	logic [AW-1:0] addr_r;
	logic [7:0] data_r;
	logic err_mode_r;
	logic err_prot_r;
	logic err_verify_r;
	logic ctrl_dir_r;
	logic ctrl_bank_r;
	logic exec_r;
	logic ack_req_r;
	logic [31:0] blink_cnt_r;
	logic blink_r;
	logic wb_hit;
	logic wb_wr;
	logic in_xfer;
	logic src_req;
	logic dst_req;
	logic src_ack;
	logic dst_ack;
	logic [7:0] src_rdata;
	logic [7:0] dst_rdata;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sw_meta_r <= 8'h00;
			sw_sync_r <= 8'h00;
			mnt_meta_r <= 1'h0;
			mnt_sync_r <= 1'h0;
		end
		else
		begin
			sw_meta_r <= {protect_group_reserved_in, auto_bank_select_in, unit_write_enable_in,
				term_write_enable_in, mode_group_reserved_in, manual_xfer_sel_in,
				auto_term_to_unit_sel_in, auto_unit_to_term_sel_in};
			sw_sync_r <= sw_meta_r;
			mnt_meta_r <= unit_mounted_in;
			mnt_sync_r <= mnt_meta_r;
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	// one wait state: ack one cycle after the strobe, dropped the next
	assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
	// a write lands on the edge at which the master sees ack high, never earlier
	assign wb_wr = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0] && (wb_adr_in == SDT_OFS_CTRL);

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			wb_ack_out <= 1'h0;
		else
			wb_ack_out <= wb_hit;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ctrl_dir_r <= SDT_CTRL_DIR_RST;
			ctrl_bank_r <= SDT_CTRL_BANK_RST;
			exec_r <= 1'h0;
			ack_req_r <= 1'h0;
		end
		else
		begin
			exec_r <= wb_wr && wb_dat_in[SDT_CTRL_EXEC_BIT];
			ack_req_r <= wb_wr && wb_dat_in[SDT_CTRL_ACK_BIT];
			if (wb_wr)
			begin
				ctrl_dir_r <= wb_dat_in[SDT_CTRL_DIR_BIT];
				ctrl_bank_r <= wb_dat_in[SDT_CTRL_BANK_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			wb_dat_out <= 32'h0000_0000;
		else if (wb_hit && !wb_we_in)
		begin
			wb_dat_out <= 32'h0000_0000;
			case (wb_adr_in)
				SDT_OFS_CTRL:
				begin
					wb_dat_out[SDT_CTRL_DIR_BIT] <= ctrl_dir_r;
					wb_dat_out[SDT_CTRL_BANK_BIT] <= ctrl_bank_r;
				end
				SDT_OFS_STATUS:
				begin
					wb_dat_out[SDT_ST_PHASE_LSB +: 4] <= phase_out;
					wb_dat_out[SDT_ST_MODE_ERR_BIT] <= err_mode_r;
					wb_dat_out[SDT_ST_PROT_ERR_BIT] <= err_prot_r;
					wb_dat_out[SDT_ST_VERIFY_ERR_BIT] <= err_verify_r;
					wb_dat_out[SDT_ST_AUTO_BIT] <= auto_r;
					wb_dat_out[SDT_ST_MANUAL_BIT] <= manual_r;
					wb_dat_out[SDT_ST_DIR_BIT] <= dir_r;
					wb_dat_out[SDT_ST_BANK_BIT] <= bank_r;
					wb_dat_out[SDT_ST_MOUNTED_BIT] <= mnt_sync_r;
					wb_dat_out[SDT_ST_WAIT_EXEC_BIT] <= (state_r == SDT_MAN_IDLE);
				end
				// progress in bytes within the bank
				SDT_OFS_PROGRESS:
					wb_dat_out[AW-1:0] <= addr_r;
				SDT_OFS_SWITCH:
					wb_dat_out[7:0] <= sw_lat_r;
				default:
					wb_dat_out <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// memory port steering
	// ------------------------------------------------------------
	// dir 0: unit is the source, terminal the destination; dir 1 the reverse
	assign in_xfer = (state_r == SDT_XMIT) || (state_r == SDT_VERIFY);
	assign src_req = in_xfer && !step_r;
	assign dst_req = in_xfer && step_r;
	assign src_ack = dir_r ? term_ack_in : unit_ack_in;
	assign dst_ack = dir_r ? unit_ack_in : term_ack_in;
	assign src_rdata = dir_r ? term_rdata_in : unit_rdata_in;
	assign dst_rdata = dir_r ? unit_rdata_in : term_rdata_in;

	assign term_req_out = dir_r ? src_req : dst_req;
	assign unit_req_out = dir_r ? dst_req : src_req;
	// terminal only ever written when it is the destination and enabled
	assign term_we_out = (state_r == SDT_XMIT) && step_r && !dir_r && sw_lat_r[SDT_SW_TERM_WE];
	assign unit_we_out = (state_r == SDT_XMIT) && step_r && dir_r && sw_lat_r[SDT_SW_UNIT_WE];
	assign term_addr_out = addr_r;
	assign unit_addr_out = {bank_r, addr_r};
	assign term_wdata_out = data_r;
	assign unit_wdata_out = data_r;

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= SDT_SAMPLE;
			sw_lat_r <= 8'h00;
			cnt_r <= 32'h0000_0000;
			auto_r <= 1'h0;
			manual_r <= 1'h0;
			dir_r <= 1'h0;
			bank_r <= 1'h0;
			step_r <= 1'h0;
			addr_r <= '0;
			data_r <= 8'h00;
			err_mode_r <= 1'h0;
			err_prot_r <= 1'h0;
			err_verify_r <= 1'h0;
		end
		else
		begin
			case (state_r)
				// let the synchronised switches settle, then take one sample
				SDT_SAMPLE:
				begin
					if (cnt_r == SETTLE_MAX)
					begin
						sw_lat_r <= sw_sync_r;
						cnt_r <= 32'h0000_0000;
						state_r <= SDT_CHECK;
					end
					else
						cnt_r <= cnt_r + 32'h0000_0001;
				end
				SDT_CHECK:
				begin
					if (!one_hot3(sw_lat_r[SDT_SW_MANUAL:SDT_SW_U2T]))
					begin
						err_mode_r <= 1'h1;
						state_r <= SDT_ERR;
					end
					else if (sw_lat_r[SDT_SW_MANUAL])
					begin
						manual_r <= 1'h1;
						state_r <= SDT_MAN_IDLE;
					end
					else
					begin
						auto_r <= 1'h1;
						dir_r <= sw_lat_r[SDT_SW_T2U];
						bank_r <= sw_lat_r[SDT_SW_BANK];
						if (!dest_writable(sw_lat_r[SDT_SW_T2U], sw_lat_r))
						begin
							err_prot_r <= 1'h1;
							state_r <= SDT_ERR;
						end
						else
							state_r <= SDT_PREP;
					end
				end
				// manual copy waits for an explicit execute
				SDT_MAN_IDLE:
				begin
					if (exec_r)
					begin
						dir_r <= ctrl_dir_r;
						bank_r <= ctrl_bank_r;
						err_verify_r <= 1'h0;
						if (!dest_writable(ctrl_dir_r, sw_lat_r))
						begin
							err_prot_r <= 1'h1;
							state_r <= SDT_ERR;
						end
						else
						begin
							cnt_r <= 32'h0000_0000;
							state_r <= SDT_PREP;
						end
					end
				end
				SDT_PREP:
				begin
					if (cnt_r == PREP_MAX)
					begin
						cnt_r <= 32'h0000_0000;
						addr_r <= '0;
						step_r <= 1'h0;
						state_r <= SDT_XMIT;
					end
					else
						cnt_r <= cnt_r + 32'h0000_0001;
				end
				// each byte: read source, then write destination
				SDT_XMIT:
				begin
					if (!step_r && src_ack)
					begin
						data_r <= src_rdata;
						step_r <= 1'h1;
					end
					else if (step_r && dst_ack)
					begin
						step_r <= 1'h0;
						addr_r <= addr_r + AW'(1);
						if (addr_r == ADDR_LAST)
							state_r <= SDT_VERIFY;
					end
				end
				// each byte: read source, then read destination and compare
				SDT_VERIFY:
				begin
					if (!step_r && src_ack)
					begin
						data_r <= src_rdata;
						step_r <= 1'h1;
					end
					else if (step_r && dst_ack)
					begin
						step_r <= 1'h0;
						if (dst_rdata != data_r)
						begin
							err_verify_r <= 1'h1;
							state_r <= SDT_ERR;
						end
						else
						begin
							addr_r <= addr_r + AW'(1);
							if (addr_r == ADDR_LAST)
								state_r <= SDT_DONE;
						end
					end
				end
				SDT_DONE:
				begin
					if (manual_r && exec_r)
						state_r <= SDT_MAN_IDLE;
				end
				// only a manual protect error may be acknowledged; the rest hold
				SDT_ERR:
				begin
					if (manual_r && err_prot_r && ack_req_r)
					begin
						err_prot_r <= 1'h0;
						state_r <= SDT_MAN_IDLE;
					end
				end
				default:
					state_r <= SDT_ERR;
			endcase
		end
	end

	// ------------------------------------------------------------
	// indicators
	// ------------------------------------------------------------
	// free-running blink so every flashing phase shares one rhythm
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			blink_cnt_r <= 32'h0000_0000;
			blink_r <= 1'h0;
		end
		else if (blink_cnt_r == BLINK_MAX)
		begin
			blink_cnt_r <= 32'h0000_0000;
			blink_r <= !blink_r;
		end
		else
			blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			run_indicator_out <= 1'h0;
			alarm_out <= 1'h0;
			phase_out <= 4'h0;
			normal_op_en_out <= 1'h0;
		end
		else
		begin
			alarm_out <= (state_r == SDT_ERR);
			phase_out <= {state_r == SDT_DONE, state_r == SDT_VERIFY,
				state_r == SDT_XMIT, state_r == SDT_PREP};
			// normal operation only once no unit is seen
			normal_op_en_out <= !mnt_sync_r;
			if (state_r == SDT_ERR)
				run_indicator_out <= blink_r;
			else if (manual_r)
				run_indicator_out <= 1'h0;
			else if (auto_r && (state_r == SDT_DONE))
				run_indicator_out <= 1'h1;
			else if (auto_r && (state_r == SDT_PREP || in_xfer))
				run_indicator_out <= blink_r;
			else
				run_indicator_out <= 1'h0;
		end
	end
endmodule

// [dv/sdt_ctrl_asserts.sv]
// port assertions for the transfer controller
`timescale 1ns/100ps
module sdt_ctrl_chk #(
	parameter int AW = 4,
	parameter int BLINK_HALF_CYC = 8
)
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// switches and presence
	input wire logic manual_xfer_sel_in,
	input wire logic term_write_enable_in,
	input wire logic unit_write_enable_in,
	input wire logic auto_bank_select_in,
	input wire logic unit_mounted_in,
	// memory ports
	input wire logic term_req_out,
	input wire logic term_we_out,
	input wire logic unit_req_out,
	input wire logic unit_we_out,
	input wire logic [AW:0] unit_addr_out,
	// indicators
	input wire logic run_indicator_out,
	input wire logic alarm_out,
	input wire logic [3:0] phase_out,
	input wire logic normal_op_en_out
);
	logic [31:0] steady_r;
	logic blink_due;
	logic term_wr;
	logic unit_wr;
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	assign term_wr = term_req_out && term_we_out;
	assign unit_wr = unit_req_out && unit_we_out;
	assign blink_due = alarm_out || ((|phase_out[2:0]) && !manual_xfer_sel_in);
	// a counter, since a repetition this long would choke the tools
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			steady_r <= 32'h0;
		else if (blink_due && $stable(run_indicator_out))
			steady_r <= steady_r + 32'h1;
		else
			steady_r <= 32'h0;
	end
	// ----
	// assertions
	// ----
	AST_PHASE_ORDER: assert property ($changed(phase_out) && phase_out != 4'h0 |->
		phase_out == {$past(phase_out[2:0]), 1'b0} || ($past(phase_out) == 4'h0 && phase_out == 4'h1))
		else $error("phase out of order");
	AST_DONE_LIT: assert property (phase_out[3] && $past(phase_out[3]) && !alarm_out && !manual_xfer_sel_in |->
		run_indicator_out) else $error("indicator dark when finished");
	AST_BLINK: assert property (steady_r <= BLINK_HALF_CYC + 2)
		else $error("indicator not flashing");
	AST_ALARM_HOLD: assert property (alarm_out && !manual_xfer_sel_in |=> alarm_out)
		else $error("alarm released");
	AST_MAN_DARK: assert property (manual_xfer_sel_in && !alarm_out && !$past(alarm_out) |-> !run_indicator_out)
		else $error("indicator lit in manual mode");
	AST_MOUNT: assert property ($stable(unit_mounted_in) [*5] |-> normal_op_en_out == !unit_mounted_in)
		else $error("normal state ignores mount");
	AST_TERM_PROT: assert property (!term_write_enable_in |-> !term_wr)
		else $error("terminal write while protected");
	AST_UNIT_PROT: assert property (!unit_write_enable_in |-> !unit_wr)
		else $error("unit write while protected");
	AST_AUTO_BANK: assert property (unit_wr && !manual_xfer_sel_in |-> unit_addr_out[AW] == auto_bank_select_in)
		else $error("wrong bank written");
	AST_VERIFY_RO: assert property (phase_out[2] |-> !term_wr && !unit_wr)
		else $error("write during verify");
endmodule
bind sdt_ctrl sdt_ctrl_chk #(.AW(AW), .BLINK_HALF_CYC(BLINK_HALF_CYC)) chk (.sys_clk_in(sys_clk_in),
	.rst_n_in(rst_n_in), .manual_xfer_sel_in(manual_xfer_sel_in), .term_write_enable_in(term_write_enable_in),
	.unit_write_enable_in(unit_write_enable_in), .auto_bank_select_in(auto_bank_select_in),
	.unit_mounted_in(unit_mounted_in), .term_req_out(term_req_out), .term_we_out(term_we_out),
	.unit_req_out(unit_req_out), .unit_we_out(unit_we_out), .unit_addr_out(unit_addr_out),
	.run_indicator_out(run_indicator_out), .alarm_out(alarm_out), .phase_out(phase_out),
	.normal_op_en_out(normal_op_en_out));

// [dv/sdt_mem_model.sv]
// byte-wide flash model used for terminal and memory unit
`timescale 1ns/100ps
module sdt_mem_model #(
	parameter int AW = 4
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// access port
	input wire logic req_in,
	input wire logic we_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	output logic ack_out,
	// behaviour: wait cycles, corrupt reads
	input wire logic [1:0] lat_in,
	input wire logic bad_in
);
	logic [7:0] mem [2**AW];
	logic [1:0] wait_r;
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack_out <= 1'b0;
			wait_r <= 2'h0;
		end
		else if (req_in && !ack_out && wait_r == lat_in)
		begin
			ack_out <= 1'b1;
			wait_r <= 2'h0;
			if (we_in)
				mem[addr_in] <= wdata_in;
			rdata_out <= bad_in ? ~mem[addr_in] : mem[addr_in];
		end
		else
		begin
			ack_out <= 1'b0;
			wait_r <= (req_in && !ack_out) ? wait_r + 2'h1 : 2'h0;
			// data only valid with ack, so scramble it between answers
			rdata_out <= ~rdata_out;
		end
	end
endmodule

// [dv/sdt_ctrl_test.sv]
// bench: boots the controller in a series of switch settings against two flash models
`timescale 1ns/100ps
module sdt_ctrl_test
	import sdt_pkg::*;
();
	localparam int AW = 4;
	logic clk, rst_n, cyc, stb, we, ack, mnt, bad, t_req, t_we, t_ack, u_req, u_we, u_ack, run_ind, alarm, norm_en;
	logic [1:0] lat;
	logic [3:0] sel;
	logic [3:0] phase;
	logic [7:0] adr, sw, t_wd, t_rd, u_wd, u_rd;
	logic [AW-1:0] t_addr;
	logic [AW:0] u_addr;
	logic [31:0] dat_w, dat_r, q;
	logic [7:0] modes [3] = '{8'h30, 8'h33, 8'h35};
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	sdt_ctrl #(.AW(AW), .BLINK_HALF_CYC(8)) DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
		.wb_ack_out(ack), .auto_unit_to_term_sel_in(sw[0]), .auto_term_to_unit_sel_in(sw[1]),
		.manual_xfer_sel_in(sw[2]), .mode_group_reserved_in(sw[3]), .term_write_enable_in(sw[4]),
		.unit_write_enable_in(sw[5]), .auto_bank_select_in(sw[6]), .protect_group_reserved_in(sw[7]),
		.unit_mounted_in(mnt), .term_req_out(t_req), .term_we_out(t_we), .term_addr_out(t_addr),
		.term_wdata_out(t_wd), .term_rdata_in(t_rd), .term_ack_in(t_ack), .unit_req_out(u_req),
		.unit_we_out(u_we), .unit_addr_out(u_addr), .unit_wdata_out(u_wd), .unit_rdata_in(u_rd),
		.unit_ack_in(u_ack), .run_indicator_out(run_ind), .alarm_out(alarm), .phase_out(phase),
		.normal_op_en_out(norm_en));
	sdt_mem_model #(.AW(AW)) trm (.clk_in(clk), .rst_n_in(rst_n), .req_in(t_req), .we_in(t_we),
		.addr_in(t_addr), .wdata_in(t_wd), .rdata_out(t_rd), .ack_out(t_ack), .lat_in(lat), .bad_in(bad));
	sdt_mem_model #(.AW(AW + 1)) unt (.clk_in(clk), .rst_n_in(rst_n), .req_in(u_req), .we_in(u_we),
		.addr_in(u_addr), .wdata_in(u_wd), .rdata_out(u_rd), .ack_out(u_ack), .lat_in(lat), .bad_in(1'b0));
	// ----
	// tasks
	// ----
	function automatic logic [7:0] pat(input int k, input int i);
		return (k == 0) ? 8'h80 + i[7:0] : (k == 1) ? 8'h10 + i[7:0] : 8'h5a ^ i[7:0];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		dat_w <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		r = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic poll(input int b);
		logic [31:0] r;
		r = 32'h0;
		while (r[b] !== 1'b1)
			wb(1'b0, SDT_OFS_STATUS, 32'h0, r);
	endtask
	task automatic boot(input logic [7:0] s, input logic m);
		@(posedge clk);
		rst_n <= 1'b0;
		sw <= s;
		mnt <= m;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic load;
		for (int i = 0; i < 16; i++)
		begin
			trm.mem[i] = pat(0, i);
			unt.mem[i] = pat(1, i);
			unt.mem[16 + i] = pat(2, i);
		end
	endtask
	task automatic mcheck(input logic u, input int base, input int k);
		for (int i = 0; i < 16; i++)
			check({24'h0, u ? unt.mem[base + i] : trm.mem[i]}, {24'h0, pat(k, i)});
	endtask
	// ----
	// run
	// ----
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			errors++;
			summarize();
		end
	end
	initial
	begin
		{rst_n, cyc, stb, we, sel, bad, lat, adr, dat_w, sw, mnt} = '0;
		load();
		boot(8'h51, 1'b1);
		poll(3);
		repeat (2) @(posedge clk);
		check(32'(phase), 32'h8);
		check(32'(run_ind), 32'h1);
		check(32'(norm_en), 32'h0);
		mcheck(1'b0, 0, 2);
		wb(1'b1, SDT_OFS_STATUS, 32'hffff, q);
		wb(1'b0, SDT_OFS_STATUS, 32'h0, q);
		check(q & 32'h70, 32'h0);
		wb(1'b0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		// slow flash; a switch moved mid-session must not count
		lat <= 2'h2;
		load();
		boot(8'h22, 1'b1);
		poll(3);
		sw <= 8'h62;
		wb(1'b0, SDT_OFS_SWITCH, 32'h0, q);
		check(q, 32'h22);
		mcheck(1'b1, 0, 0);
		mcheck(1'b1, 16, 2);
		mcheck(1'b0, 0, 0);
		load();
		boot(8'h12, 1'b1);
		poll(5);
		check(32'(alarm), 32'h1);
		mcheck(1'b1, 0, 1);
		for (int j = 0; j < 3; j++)
		begin
			boot(modes[j], 1'b0);
			poll(4);
			check(32'(alarm), 32'h1);
			check(32'(norm_en), 32'h1);
		end
		lat <= 2'h1;
		load();
		boot(8'h34, 1'b1);
		poll(12);
		wb(1'b1, SDT_OFS_CTRL, 32'h7, q);
		poll(3);
		check(32'(run_ind), 32'h0);
		mcheck(1'b1, 16, 0);
		wb(1'b0, SDT_OFS_CTRL, 32'h0, q);
		check(q & 32'h6, 32'h6);
		// an execute after finished only returns to waiting; the next one copies bank 0 in
		wb(1'b1, SDT_OFS_CTRL, 32'h1, q);
		poll(12);
		wb(1'b1, SDT_OFS_CTRL, 32'h1, q);
		poll(3);
		check(32'(run_ind), 32'h0);
		mcheck(1'b0, 0, 1);
		boot(8'h14, 1'b1);
		poll(12);
		wb(1'b1, SDT_OFS_CTRL, 32'h3, q);
		poll(5);
		mcheck(1'b1, 0, 1);
		wb(1'b1, SDT_OFS_CTRL, 32'h8, q);
		poll(12);
		check(32'(alarm), 32'h0);
		// terminal reads back corrupted during verify
		load();
		bad <= 1'b1;
		boot(8'h51, 1'b1);
		poll(6);
		check(32'(phase[3]), 32'h0);
		wb(1'b0, SDT_OFS_PROGRESS, 32'h0, q);
		check(q, 32'h0);
		summarize();
	end
endmodule
